// [cascaded_twelve_bit_pwm.sv]
// Cascaded 12-bit PWM timer with its AXI4-Lite register slave
// Behaviour
// - duty value from two nibbles, 256-count cycle
// - unused high bits stored and read back
// - each extra-pulse bit picks fixed cycles
// - bits combine for one to fifteen insertions
// - initial-level bit sets pin idle level
// - stopped timer drives initial level on pin
// - run bit makes counter step per tick
// - duty match inverts the output pin
// - selected cycles match at duty plus one
// - all extra bits zero, no stretch
// - at 256 wrap to zero, restore level
// - overflow pulse on every overflow
// - second pulse on every sixteenth overflow
// - clearing run stops, clears, restores pin
// - buffer enable bit selects buffered update
// - mode active when cascaded, field is 10
// - high register write commits both values
// - buffered value loads at sixteenth overflow
// - mode writes ignored while running
`timescale 1ns/1ps
`default_nettype none
module cascaded_twelve_bit_pwm
  import pwm12_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              external_clock_pin,
  output logic                   duty_output_pin,
  output logic                   overflow_irq,
  output logic                   sixteenth_overflow_irq
);
  // Highest index is 0x2C, so byte addresses need eight bits
  if (ADDR_W < 8)
  begin : g_chk
    $error("cascaded_twelve_bit_pwm: ADDR_W must be at least 8");
  end

  typedef struct packed {
    logic [7:0]  lowr;      // Low register: duty low nibble, extra bits
    logic [7:0]  highr;     // High register: duty high nibble in low bits
    logic [7:0]  mode;      // Upper timer mode register
    logic [7:0]  ctrl;      // Pair control register
    logic [11:0] active;    // Compare value in use
    logic [11:0] buffer;    // Last value written
    logic [7:0]  count;     // Up counter
    logic [3:0]  cyc;       // Cycle index within sixteen
    logic        matched;   // Duty match seen this cycle
    logic        pin;       // Output pin level
    logic        ovf;       // Overflow pulse
    logic        six;       // Sixteenth overflow pulse
    logic        aw_held;   // Write address captured
    logic [7:0]  aw_addr;   // Captured write address
    logic        w_held;    // Write data captured
    logic [7:0]  w_data;    // Captured write data
    logic        w_strb0;   // Captured lane 0 strobe
    logic        awready;   // Address channel ready
    logic        wready;    // Data channel ready
    logic        bvalid;    // Write response pending
    logic [1:0]  bresp;     // Write response code
    logic        arready;   // Read address ready
    logic        rvalid;    // Read data pending
    logic [31:0] rdata;     // Read data
    logic [1:0]  rresp;     // Read response code
  } pwm_state_t;

  localparam pwm_state_t STATE_RESET = '{
    lowr: LOW_RESET, highr: HIGH_RESET, mode: MODE_RESET, ctrl: CTRL_RESET,
    active: COMPARE_RESET, buffer: COMPARE_RESET, awready: 1'b1, wready: 1'b1,
    arready: 1'b1, default: '0};

  pwm_state_t s;          // Registered state
  pwm_state_t next_s;     // Next state
  logic       tick;       // Source clock tick
  logic       pwm_on;     // Mode selected and running
  logic [7:0] duty;       // Active duty value
  logic       stretch;    // This cycle gets the extra count
  logic [8:0] target;     // Count at which the pin inverts
  logic       wrap;       // Overflow this clock
  logic       hi_wr;      // High register write this clock
  logic       xfer;       // Buffered transfer this clock
  logic [7:0] wr_idx;     // Decoded write index
  logic [7:0] rd_idx;     // Decoded read index
  logic [11:0] combined;  // Value committed by a high write

  // Word index from a byte address
  function automatic logic [7:0] word_idx(input logic [7:0] a);
    word_idx = {2'h0, a[7:2]};
  endfunction

  // mode decode from cascade, field and run bit
  assign pwm_on = s.ctrl[CASCADE_BIT] && s.ctrl[UP_RUN_BIT]
               && s.mode[MODE_SEL_LSB +: 2] == PWM_MODE;
  assign duty = s.active[11:4];
  // cycle selection from the extra bits
  assign stretch = extra_hit(s.active[3:0], s.cyc);
  assign target = {1'b0, duty} + {8'h00, stretch};
  assign wrap = pwm_on && tick && s.count == COUNT_TOP;
  assign wr_idx = word_idx(s.aw_addr);
  assign rd_idx = word_idx(araddr[7:0]);

  source_tick #(
    .PRE_W (11)
  ) u_tick (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .enable       (pwm_on),
    .ext_sel      (s.mode[EXT_BIT]),
    .prescale_sel (s.mode[TCK_LSB +: 3]),
    .ext_clock    (external_clock_pin),
    .tick         (tick)
  );

  // Timer, register writes and bus answers
  always_comb
  begin
    next_s = s;
    next_s.ovf = 1'b0;
    next_s.six = 1'b0;
    hi_wr = 1'b0;
    xfer = 1'b0;
    combined = {s.w_data[3:0], s.lowr};
    if (!pwm_on)
    begin
      // stopped: cleared, pin at idle level
      next_s.count = 8'h00;
      next_s.cyc = 4'h0;
      next_s.matched = 1'b0;
      next_s.pin = s.mode[INIT_BIT];
    end
    else
    begin
      // first match in the cycle inverts the pin
      if (!s.matched && {1'b0, s.count} == target && !wrap)
      begin
        next_s.pin = !s.mode[INIT_BIT];
        next_s.matched = 1'b1;
      end
      if (wrap)
      begin
        next_s.count = 8'h00;
        next_s.cyc = s.cyc + 4'h1;
        next_s.matched = 1'b0;
        next_s.pin = s.mode[INIT_BIT];
        next_s.ovf = 1'b1;
        next_s.six = s.cyc == LAST_CYCLE;
        if (s.cyc == LAST_CYCLE && s.mode[DBE_BIT])
        begin
          next_s.active = s.buffer;
          xfer = 1'b1;
        end
      end
      else if (tick)
        next_s.count = s.count + 8'h01;
    end

    // Channel capture, address and data in either order
    if (awvalid && s.awready)
    begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = awaddr[7:0];
    end
    if (wvalid && s.wready)
    begin
      next_s.w_held = 1'b1;
      next_s.w_data = wdata[7:0];
      next_s.w_strb0 = wstrb[0];
    end
    if (bready && s.bvalid)
      next_s.bvalid = 1'b0;

    // Register write once both halves are held
    if (s.aw_held && s.w_held && !s.bvalid)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      case (wr_idx)
        LOW_IDX:
          if (s.w_strb0)
            next_s.lowr = s.w_data;
        HIGH_IDX:
          if (s.w_strb0)
          begin
            // all eight bits kept as written
            next_s.highr = s.w_data;
            // both halves commit on the high write
            hi_wr = 1'b1;
            next_s.buffer = combined;
            if (!(pwm_on && s.mode[DBE_BIT]))
              next_s.active = combined;
          end
        MODE_IDX:
          // locked while either run bit is set
          if (s.w_strb0 && !s.ctrl[LOW_RUN_BIT] && !s.ctrl[UP_RUN_BIT])
            next_s.mode = s.w_data;
        CTRL_IDX:
          if (s.w_strb0)
            next_s.ctrl = {5'h00, s.w_data[2:0]};
        STAT_IDX:
          ; // Read only, write ignored
        default:
          next_s.bresp = RESP_SLVERR;
      endcase
    end

    // Read answer
    if (arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      case (rd_idx)
        LOW_IDX:  next_s.rdata = {24'h0, s.lowr};
        HIGH_IDX: next_s.rdata = {24'h0, s.highr};
        MODE_IDX: next_s.rdata = {24'h0, s.mode};
        CTRL_IDX: next_s.rdata = {24'h0, s.ctrl};
        STAT_IDX: next_s.rdata = {18'h0, pwm_on, s.pin, s.cyc, s.count};
        default:
        begin
          next_s.rdata = 32'h0;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (rready && s.rvalid)
      next_s.rvalid = 1'b0;

    // Ready only while nothing is pending on that channel
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready = !next_s.w_held && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end

  // State register, synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= STATE_RESET;
    else
      s <= next_s;
  end

  // Outputs straight from the state flops
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign duty_output_pin = s.pin;
  assign overflow_irq = s.ovf;
  assign sixteenth_overflow_irq = s.six;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // idle level follows the initial-level bit
  stop_pin_idle_a: assert property (!pwm_on |=> s.pin == $past(s.mode[INIT_BIT]))
    else $error("pin not at idle level while stopped");
  stop_clears_a: assert property ($fell(pwm_on) |-> ##1 (s.count == 8'h00 && s.cyc == 4'h0))
    else $error("counter not cleared on stop");
  // counter steps by one per tick
  count_step_a: assert property (pwm_on && tick && s.count != COUNT_TOP
      |=> s.count == 8'($past(s.count) + 8'h01))
    else $error("counter did not step");
  overflow_wrap_a: assert property (wrap
      |=> (s.count == 8'h00 && overflow_irq && s.pin == $past(s.mode[INIT_BIT])))
    else $error("overflow did not wrap");
  // sixteenth pulse only with overflow on wrap to cycle zero
  sixteenth_pulse_a: assert property (sixteenth_overflow_irq |-> overflow_irq && s.cyc == 4'h0)
    else $error("sixteenth pulse out of place");
  match_toggle_a: assert property (pwm_on && !s.matched && {1'b0, s.count} == target && !wrap
      |=> s.pin != $past(s.mode[INIT_BIT]))
    else $error("pin not inverted on match");
  // stretched cycle skips the plain duty match
  extra_delay_a: assert property (pwm_on && stretch && !s.matched && s.count == duty
      |=> !s.matched && s.pin == $past(s.mode[INIT_BIT]))
    else $error("stretched cycle inverted at plain duty");
  // no extra bits, plain duty match inverts
  no_extra_a: assert property (pwm_on && s.active[3:0] == 4'h0 && !s.matched
      && s.count == duty && !wrap |=> s.pin != $past(s.mode[INIT_BIT]))
    else $error("plain cycle missed duty match");
  mode_lock_a: assert property ((s.ctrl[LOW_RUN_BIT] || s.ctrl[UP_RUN_BIT])
      |=> s.mode == $past(s.mode))
    else $error("mode changed while running");
  // compare value changes only on high write or transfer
  commit_point_a: assert property (s.active != $past(s.active) |-> $past(hi_wr || xfer))
    else $error("compare value changed without commit");
  // buffered write while running leaves compare value alone
  buffered_write_a: assert property (hi_wr && pwm_on && s.mode[DBE_BIT] && !xfer
      |=> s.active == $past(s.active))
    else $error("buffered write reached compare value");
  // high register keeps all written bits
  high_keep_a: assert property (hi_wr |=> s.highr == $past(s.w_data))
    else $error("high register lost bits");

  overflow_c: cover property (wrap);
  sixteenth_c: cover property (sixteenth_overflow_irq && s.mode[DBE_BIT]);
  stretch_c: cover property (pwm_on && stretch && s.matched);
  mode_blocked_c: cover property (s.ctrl[UP_RUN_BIT] && s.aw_held && s.w_held
      && wr_idx == MODE_IDX);
endmodule
`default_nettype wire

// [pwm12_pkg.sv]
// Constants, register map and helper functions for the cascaded 12-bit PWM block
package pwm12_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] LOW_IDX  = 8'h28;
  localparam logic [7:0] HIGH_IDX = 8'h29;
  localparam logic [7:0] MODE_IDX = 8'h2A;
  localparam logic [7:0] CTRL_IDX = 8'h2B;
  localparam logic [7:0] STAT_IDX = 8'h2C;
  // Values after reset
  localparam logic [7:0]  LOW_RESET     = 8'hFF;
  localparam logic [7:0]  HIGH_RESET    = 8'hFF;
  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [11:0] COMPARE_RESET = 12'hFFF;
  // Mode register fields
  localparam int MODE_SEL_LSB = 0;
  localparam int EXT_BIT      = 2;
  localparam int TCK_LSB      = 3;
  localparam int DBE_BIT      = 6;
  localparam int INIT_BIT     = 7;
  localparam logic [1:0] PWM_MODE = 2'h2;
  // Control register fields
  localparam int LOW_RUN_BIT = 0;
  localparam int UP_RUN_BIT  = 1;
  localparam int CASCADE_BIT = 2;
  // Counter limits
  localparam logic [7:0] COUNT_TOP  = 8'hFF;
  localparam logic [3:0] LAST_CYCLE = 4'hF;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Divider exponent for each internal clock selection
  function automatic logic [3:0] prescale_exp(input logic [2:0] sel);
    case (sel)
      3'h0:    prescale_exp = 4'hB;
      3'h1:    prescale_exp = 4'hA;
      3'h2:    prescale_exp = 4'h8;
      3'h3:    prescale_exp = 4'h6;
      3'h4:    prescale_exp = 4'h4;
      3'h5:    prescale_exp = 4'h2;
      3'h6:    prescale_exp = 4'h1;
      default: prescale_exp = 4'h0;
    endcase
  endfunction

  // One if the cycle with index idx (cycle number idx+1) gets a stretched pulse
  function automatic logic extra_hit(input logic [3:0] ad, input logic [3:0] idx);
    logic [3:0] c;
    c = idx + 4'h1;
    extra_hit = (ad[3] && !c[0]) || (ad[2] && c[1:0] == 2'h3)
             || (ad[1] && c[2:0] == 3'h5) || (ad[0] && idx == 4'h8);
  endfunction
endpackage

// [source_tick.sv]
// Source clock tick generator: internal prescaler or external falling edge
`timescale 1ns/1ps
`default_nettype none
module source_tick
  import pwm12_pkg::*;
#(
  parameter int PRE_W = 11
)(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       enable,
  input  wire logic       ext_sel,
  input  wire logic [2:0] prescale_sel,
  input  wire logic       ext_clock,
  output logic            tick
);
  // The slowest selection divides by two to the eleventh
  if (PRE_W < 11)
  begin : g_chk
    $error("source_tick: PRE_W must be at least 11");
  end

  typedef struct packed {
    logic [PRE_W-1:0] pre;       // Prescaler count
    logic             ext_prev;  // Last external level
    logic             tick;      // One-cycle source tick
  } tick_state_t;

  tick_state_t s;       // Registered state
  tick_state_t next_s;  // Next state
  logic [PRE_W:0] wide; // Mask before trimming

  // Next state
  always_comb
  begin
    next_s = s;
    next_s.ext_prev = ext_clock;
    next_s.tick = 1'b0;
    wide = ((PRE_W+1)'(1) << prescale_exp(prescale_sel)) - (PRE_W+1)'(1);
    if (!enable)
      // Idle prescaler restarts cleanly at the next run
      next_s.pre = '0;
    else if (ext_sel)
      // edges spaced by the far clock source
      next_s.tick = s.ext_prev && !ext_clock;
    else
    begin
      next_s.pre = s.pre + PRE_W'(1);
      next_s.tick = (s.pre & wide[PRE_W-1:0]) == wide[PRE_W-1:0];
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick = s.tick;
endmodule
`default_nettype wire

// [ext_clock_source.sv]
// External source clock model that feeds the timer input pin
`timescale 1ns/1ps
`default_nettype none
module ext_clock_source
#(
  parameter int HALF = 4
)(
  input  wire logic aclk,
  input  wire logic enable,
  output logic      clk_out
);
  int cnt = 0; // Cycles spent in the current level

  // Level toggles every HALF cycles while enabled
  // slow clock, long levels
  always @(posedge aclk)
  begin
    // Idle high, so no stray falling edge reaches the timer
    if (!enable)
    begin
      cnt     <= 0;
      clk_out <= 1'b1;
    end
    // End of a level
    else if (cnt == HALF - 1)
    begin
      cnt     <= 0;
      clk_out <= ~clk_out;
    end
    else
      cnt <= cnt + 1;
  end
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking testbench for the cascaded 12-bit PWM timer
`timescale 1ns/1ps
`default_nettype none
module tb
  import pwm12_pkg::*;
;
  localparam int HALF = 4; // External clock half period in aclk cycles
  logic        aclk = 1'b0;                        // 125 MHz clock
  logic        aresetn;                            // Synchronous reset, active low
  logic [7:0]  awaddr, araddr;                     // Byte addresses
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, wr_resp, rd_resp;
  logic        ext_pin, ext_en, pin, ovf, six;     // Timer pins
  int          errors = 0, num_checks = 0;         // Verdict counters
  int          hi_cnt = 0, hi_snap = 0;            // Pin high cycles per window
  int          ov_cnt = 0, ov_snap = 0;            // Overflows per window
  int          gap = 0, gap_snap = 0;              // Cycles between overflows
  int          ov_all = 0, six_n = 0;              // Running pulse totals
  // Duty and extra-pulse table; extra bits give 1, 2, 4, 8 cycles each
  logic [3:0]  ad_t [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hF};
  logic [7:0]  dl_t [6] = '{8'h14, 8'h14, 8'h14, 8'h14, 8'h14, 8'h00};
  logic [7:0]  mf_t [2] = '{8'h39, 8'h3B};         // Modes other than PWM

  always #4 aclk = ~aclk;

  cascaded_twelve_bit_pwm u_cascaded_twelve_bit_pwm (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .external_clock_pin(ext_pin), .duty_output_pin(pin),
    .overflow_irq(ovf), .sixteenth_overflow_irq(six)
  );

  ext_clock_source #(.HALF(HALF)) u_ext_clock_source (
    .aclk(aclk), .enable(ext_en), .clk_out(ext_pin)
  );

  // Window totals restart at each sixteenth pulse; any 4096 cycles see one pattern
  always @(posedge aclk)
  begin
    if (six === 1'b1)
    begin
      hi_snap <= hi_cnt;
      ov_snap <= ov_cnt;
      hi_cnt  <= int'(pin === 1'b1);
      ov_cnt  <= int'(ovf === 1'b1);
      six_n   <= six_n + 1;
    end
    else
    begin
      hi_cnt <= hi_cnt + int'(pin === 1'b1);
      ov_cnt <= ov_cnt + int'(ovf === 1'b1);
    end
    // Overflow spacing
    if (ovf === 1'b1)
    begin
      gap_snap <= gap;
      gap      <= 1;
      ov_all   <= ov_all + 1;
    end
    else
      gap <= gap + 1;
  end

  task automatic stop_test();
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One write; each half released once taken, response kept in wr_resp
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    int n;
    awaddr  <= {idx[5:0], 2'b00};
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      n++;
    end
    while (bvalid !== 1'b1 && n < 64);
    wr_resp = bresp;
    bready  <= 1'b0;
    if (n == 64)
      errors++;
    @(posedge aclk);
  endtask

  // One read; data and response kept in rd_val and rd_resp
  task automatic rd(input logic [7:0] idx);
    int n;
    araddr  <= {idx[5:0], 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      n++;
    end
    while (rvalid !== 1'b1 && n < 64);
    rd_val  = rdata;
    rd_resp = rresp;
    rready  <= 1'b0;
    if (n == 64)
      errors++;
    @(posedge aclk);
  endtask

  // Wait until a pulse total has grown by k, bounded by lim cycles
  task automatic wait_on(ref int c, input int k, input int lim);
    int s;
    s = c + k;
    for (int i = 0; i < lim && c < s; i++)
      @(posedge aclk);
    if (c < s)
      errors++;
  endtask

  // Configure while stopped, then run; mode writes are refused while running
  // low before high
  task automatic start(input logic [7:0] mode, input logic [7:0] lo, input logic [7:0] hi);
    wr(CTRL_IDX, 8'h00);
    wr(MODE_IDX, mode);
    wr(LOW_IDX, lo);
    wr(HIGH_IDX, hi);
    wr(CTRL_IDX, 8'h06);
  endtask

  initial
  begin
    int s;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ext_en} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata  = 32'h0;
    wstrb  = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Values after reset and idle pin
    rd(LOW_IDX);
    chk(rd_val, 32'h000000FF);
    rd(HIGH_IDX);
    chk(rd_val, 32'h000000FF);
    // Lane 0 strobe low: write answered but ignored
    wstrb <= 4'hE;
    wr(LOW_IDX, 8'h00);
    wstrb <= 4'hF;
    chk({30'h0, wr_resp}, 32'h0);
    rd(LOW_IDX);
    chk(rd_val, 32'h000000FF);
    chk({31'h0, pin}, 32'h0);
    // Unmapped places answer with an error code
    rd(8'h2D);
    chk({30'h0, rd_resp}, 32'h2);
    wr(8'h2E, 8'h55);
    chk({30'h0, wr_resp}, 32'h2);
    wr(HIGH_IDX, 8'hA5);
    rd(HIGH_IDX);
    chk(rd_val, 32'h000000A5);
    wr(MODE_IDX, 8'hBA);
    repeat (2) @(posedge aclk);
    chk({31'h0, pin}, 32'h1);
    wr(MODE_IDX, 8'h3A);
    repeat (2) @(posedge aclk);
    chk({31'h0, pin}, 32'h0);
    // stretched cycles; high cycles are 255 - duty, one less when stretched
    foreach (ad_t[i])
    begin
      start(8'h3A, {dl_t[i][3:0], ad_t[i]}, {4'h0, dl_t[i][7:4]});
      wait_on(six_n, 2, 9000);
      chk(hi_snap, 16 * (255 - dl_t[i]) - ad_t[i]);
      chk(ov_snap, 16);
      chk(gap_snap, 256);
    end
    ext_en <= 1'b1;
    start(8'h06, 8'h40, 8'h01);
    wait_on(ov_all, 2, 6000);
    chk(gap_snap, 2 * HALF * 256);
    ext_en <= 1'b0;
    // prescaled ticks: divide by two and by four
    start(8'h32, 8'h40, 8'h01);
    wait_on(ov_all, 2, 2000);
    chk(gap_snap, 512);
    start(8'h2A, 8'h40, 8'h01);
    wait_on(ov_all, 2, 3000);
    chk(gap_snap, 1024);
    // buffered duty waits for the sixteenth overflow
    start(8'h7A, 8'h40, 8'h01);
    wait_on(six_n, 2, 9000);
    wr(LOW_IDX, 8'h80);
    wr(HIGH_IDX, 8'h02);
    wait_on(six_n, 1, 4500);
    chk(hi_snap, 16 * (255 - 8'h14));
    wait_on(six_n, 1, 4500);
    chk(hi_snap, 16 * (255 - 8'h28));
    wr(MODE_IDX, 8'h3A);
    rd(MODE_IDX);
    chk(rd_val, 32'h0000007A);
    rd(LOW_IDX);
    chk(rd_val, 32'h00000080);
    // stop just after the pin went high, far from the wrap
    for (int i = 0; i < 300 && pin !== 1'b0; i++)
      @(posedge aclk);
    for (int i = 0; i < 300 && pin !== 1'b1; i++)
      @(posedge aclk);
    wr(CTRL_IDX, 8'h00);
    chk({31'h0, pin}, 32'h0);
    rd(STAT_IDX);
    chk({18'h0, rd_val[13:0]}, 32'h0);
    // other mode fields leave the timer idle
    foreach (mf_t[i])
    begin
      start(mf_t[i], 8'h40, 8'h01);
      s = ov_all;
      repeat (600) @(posedge aclk);
      chk(ov_all, s);
    end
    stop_test();
  end

  // Watchdog well beyond the planned run length
  initial
  begin
    repeat (95000) @(posedge aclk);
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
